// ==== rtl/xps_crosspoint_cfg.sv ====
// crosspoint serial configuration: top, switch registers and crossing
//
// Summary of operation
// - mode low: 16-bit frame programs all outputs
// - output n: bits 4n..4n+3, selector then off
// - first bit after select is position zero
// - load register shifts freely, overflow shifts out
// - mode high: short word updates one output
// - word: output 0-1, input 2-4, off 5
// - serial out carries shifted-out bits for chaining
// - chained devices share or split configure pulses
// - reset: all selectors zero, outputs off
// - broadcast: all outputs on, input zero
// - reset and broadcast ignore serial activity
// - configure pulse copies new data only once
// - serial data sampled on falling clock edges
// - deselected: data and clock ignored
`default_nettype none
`include "xps_defines.svh"
module xps_crosspoint_cfg
  import xps_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic cfg,
  input wire logic mode,
  input wire logic reset_all_off,
  input wire logic all_outputs_to_input_zero,
  output logic serial_out,
  output logic [`XPS_NOUT*`XPS_SEL_W-1:0] out_sel,
  output logic [`XPS_NOUT-1:0] out_off
);
  xps_link_if lnk ();

  logic cfg_s;
  logic mode_s;
  logic rst_s;
  logic all_outputs_to_input_zero_s;
  logic [`XPS_CNT_W-1:0] tgl_s;
  xps_word_type word_s;
  logic cfg_prev_q;
  logic [`XPS_CNT_W-1:0] ack_q;
  logic pending;
  logic apply;
  xps_mode_type mode_now;
  logic [`XPS_AWORD_W-1:0] aword;
  logic [`XPS_OUTIDX_W-1:0] a_out;
  logic [`XPS_SEL_W-1:0] a_sel;
  logic a_off;
  logic [`XPS_SEL_W-1:0] sel_q [`XPS_NOUT];
  logic off_q [`XPS_NOUT];

  // ****************************************************************
  // serial-clock side
  // ****************************************************************
  xps_link u_link (
    .sclk(sclk),
    .srst(srst),
    .cs_n(cs_n),
    .din(din),
    .lnk(lnk.link)
  );

  assign serial_out = lnk.dout;

  // ****************************************************************
  // pin and crossing synchronisers
  // ****************************************************************
  xps_sync #(.W(4)) u_pin_sync (
    .clk(clk),
    .async_in({cfg, mode, reset_all_off, all_outputs_to_input_zero}),
    .sync_out({cfg_s, mode_s, rst_s, all_outputs_to_input_zero_s})
  );

  // word is quiet while configure is low and shifting is done
  xps_sync #(.W(`XPS_FRAME_W + `XPS_CNT_W)) u_word_sync (
    .clk(clk),
    .async_in({lnk.new_tgl, lnk.word}),
    .sync_out({tgl_s, word_s})
  );

  // ****************************************************************
  // configure edge and new-data tracking
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cfg_prev_q <= 1'b0;
    end
    else
    begin
      cfg_prev_q <= cfg_s;
    end
  end

  assign pending = tgl_s != ack_q;
  assign apply = cfg_s && !cfg_prev_q && pending;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ack_q <= tgl_s;
    end
    else if (apply)
    begin
      ack_q <= tgl_s;
    end
  end

  // ****************************************************************
  // addressed word fields
  // ****************************************************************
  assign mode_now = xps_mode_type'(mode_s);
  assign aword = word_s[`XPS_AWORD_BASE +: `XPS_AWORD_W];
  assign a_out = aword[`XPS_A_OUT_LSB +: `XPS_OUTIDX_W];
  assign a_sel = aword[`XPS_A_IN_LSB +: `XPS_SEL_W];
  assign a_off = aword[`XPS_A_OFF];

  // ****************************************************************
  // switch registers, one per output
  // ****************************************************************
  for (genvar n = 0; n < `XPS_NOUT; n++)
  begin : g_out
    always_ff @(posedge clk)
    begin
      if (srst || rst_s)
      begin
        sel_q[n] <= `XPS_SEL_RST;
        off_q[n] <= `XPS_OFF_RST;
      end
      else if (all_outputs_to_input_zero_s)
      begin
        sel_q[n] <= `XPS_SEL_ALL_OUTPUTS_TO_INPUT_ZERO;
        off_q[n] <= `XPS_OFF_ALL_OUTPUTS_TO_INPUT_ZERO;
      end
      else if (apply)
      begin
        case (mode_now)
          XPS_MODE_SERIAL:
          begin
            sel_q[n] <= word_s[n*`XPS_SLOT_W +: `XPS_SEL_W];
            off_q[n] <= word_s[n*`XPS_SLOT_W + `XPS_SLOT_OFF];
          end
          XPS_MODE_ADDR:
          begin
            if (a_out == `XPS_OUTIDX_W'(n))
            begin
              sel_q[n] <= a_sel;
              off_q[n] <= a_off;
            end
          end
          default:
          begin
            sel_q[n] <= sel_q[n];
          end
        endcase
      end
    end

    assign out_sel[n*`XPS_SEL_W +: `XPS_SEL_W] = sel_q[n];
    assign out_off[n] = off_q[n];
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_reset_off;
    @(posedge clk) disable iff (srst) rst_s |=> out_off == {`XPS_NOUT{`XPS_OFF_RST}} && out_sel == '0;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("reset did not clear outputs");

  property p_reset_wins;
    @(posedge clk) disable iff (srst) rst_s && all_outputs_to_input_zero_s |=> out_off == {`XPS_NOUT{`XPS_OFF_RST}};
  endproperty
  a_reset_wins: assert property (p_reset_wins) else $error("broadcast beat reset");

  property p_all_outputs_to_input_zero_on;
    @(posedge clk) disable iff (srst) all_outputs_to_input_zero_s && !rst_s |=> out_off == '0 && out_sel == '0;
  endproperty
  a_all_outputs_to_input_zero_on: assert property (p_all_outputs_to_input_zero_on) else $error("broadcast did not set outputs");

  property p_hold;
    @(posedge clk) disable iff (srst) !apply && !rst_s && !all_outputs_to_input_zero_s |=> $stable(out_sel) && $stable(out_off);
  endproperty
  a_hold: assert property (p_hold) else $error("outputs changed without configure");

  property p_serial_load;
    @(posedge clk) disable iff (srst)
      apply && !rst_s && !all_outputs_to_input_zero_s && mode_s == 1'b0 |=>
      out_sel[`XPS_SEL_W-1:0] == $past(word_s[`XPS_SEL_W-1:0]) &&
      out_off[`XPS_NOUT-1] == $past(word_s[`XPS_FRAME_W-1]);
  endproperty
  a_serial_load: assert property (p_serial_load) else $error("serial frame misloaded");

  property p_addr_other;
    @(posedge clk) disable iff (srst)
      apply && !rst_s && !all_outputs_to_input_zero_s && mode_s == 1'b1 && a_out != 2'h0 |=>
      $stable(out_sel[`XPS_SEL_W-1:0]) && $stable(out_off[0]);
  endproperty
  a_addr_other: assert property (p_addr_other) else $error("addressed word touched other output");

  property p_addr_load;
    @(posedge clk) disable iff (srst)
      apply && !rst_s && !all_outputs_to_input_zero_s && mode_s == 1'b1 && a_out == 2'h0 |=>
      out_sel[`XPS_SEL_W-1:0] == $past(a_sel) && out_off[0] == $past(a_off);
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("addressed word misloaded");

  property p_once;
    @(posedge clk) disable iff (srst) apply ##1 $stable(tgl_s) |-> !pending;
  endproperty
  a_once: assert property (p_once) else $error("data applied twice");

  property p_pin_latency;
    @(posedge clk) disable iff (srst) $rose(reset_all_off) ##1 reset_all_off [*4] |-> ##[0:1] rst_s;
  endproperty
  a_pin_latency: assert property (p_pin_latency) else $error("reset pin not seen in time");

  property p_srst_clear;
    @(posedge clk) srst |=> out_off == {`XPS_NOUT{`XPS_OFF_RST}} && out_sel == '0;
  endproperty
  a_srst_clear: assert property (p_srst_clear) else $error("core reset did not clear outputs");

  property p_rst_over_apply;
    @(posedge clk) disable iff (srst) rst_s && apply |=> out_off == {`XPS_NOUT{`XPS_OFF_RST}};
  endproperty
  a_rst_over_apply: assert property (p_rst_over_apply) else $error("configure beat reset");

  property p_all_outputs_to_input_zero_over_apply;
    @(posedge clk) disable iff (srst) all_outputs_to_input_zero_s && !rst_s && apply |=> out_off == '0 && out_sel == '0;
  endproperty
  a_all_outputs_to_input_zero_over_apply: assert property (p_all_outputs_to_input_zero_over_apply) else $error("configure beat broadcast");

  // ****************************************************************
  // per-output checks
  // ****************************************************************
  for (genvar n = 0; n < `XPS_NOUT; n++)
  begin : g_chk
    property p_serial_slot;
      @(posedge clk) disable iff (srst)
        apply && !rst_s && !all_outputs_to_input_zero_s && mode_s == 1'b0 |=>
        out_sel[n*`XPS_SEL_W +: `XPS_SEL_W] == $past(word_s[n*`XPS_SLOT_W +: `XPS_SEL_W]) &&
        out_off[n] == $past(word_s[n*`XPS_SLOT_W + `XPS_SLOT_OFF]);
    endproperty
    a_serial_slot: assert property (p_serial_slot) else $error("serial slot misloaded");

    property p_addr_slot;
      @(posedge clk) disable iff (srst)
        apply && !rst_s && !all_outputs_to_input_zero_s && mode_s == 1'b1 && a_out == `XPS_OUTIDX_W'(n) |=>
        out_sel[n*`XPS_SEL_W +: `XPS_SEL_W] == $past(a_sel) && out_off[n] == $past(a_off);
    endproperty
    a_addr_slot: assert property (p_addr_slot) else $error("addressed slot misloaded");

    property p_addr_keep;
      @(posedge clk) disable iff (srst)
        apply && !rst_s && !all_outputs_to_input_zero_s && mode_s == 1'b1 && a_out != `XPS_OUTIDX_W'(n) |=>
        $stable(out_sel[n*`XPS_SEL_W +: `XPS_SEL_W]) && $stable(out_off[n]);
    endproperty
    a_addr_keep: assert property (p_addr_keep) else $error("addressed word touched this slot");

    property p_all_outputs_to_input_zero_slot;
      @(posedge clk) disable iff (srst)
        all_outputs_to_input_zero_s && !rst_s |=>
        out_sel[n*`XPS_SEL_W +: `XPS_SEL_W] == `XPS_SEL_ALL_OUTPUTS_TO_INPUT_ZERO && out_off[n] == `XPS_OFF_ALL_OUTPUTS_TO_INPUT_ZERO;
    endproperty
    a_all_outputs_to_input_zero_slot: assert property (p_all_outputs_to_input_zero_slot) else $error("broadcast slot wrong");

    property p_rst_slot;
      @(posedge clk) disable iff (srst)
        rst_s |=>
        out_sel[n*`XPS_SEL_W +: `XPS_SEL_W] == `XPS_SEL_RST && out_off[n] == `XPS_OFF_RST;
    endproperty
    a_rst_slot: assert property (p_rst_slot) else $error("reset slot wrong");
  end
endmodule
`default_nettype wire

// ==== rtl/xps_defines.svh ====
// constants of the crosspoint serial configuration block
`ifndef XPS_DEFINES_SVH
`define XPS_DEFINES_SVH

// ****************************************************************
// frame geometry
// ****************************************************************
`define XPS_FRAME_W 16
`define XPS_NOUT 4
`define XPS_SEL_W 3
`define XPS_SLOT_W 4
`define XPS_SLOT_OFF 3
`define XPS_OUTIDX_W 2
`define XPS_CNT_W 8
`define XPS_CNT_ONE 8'h01
`define XPS_CNT_RST 8'h00

// ****************************************************************
// addressed word, positions in the word
// ****************************************************************
`define XPS_AWORD_W 6
`define XPS_AWORD_BASE 10
`define XPS_A_OUT_LSB 0
`define XPS_A_IN_LSB 2
`define XPS_A_OFF 5

// ****************************************************************
// reset and broadcast values
// ****************************************************************
`define XPS_SEL_RST 3'h0
`define XPS_OFF_RST 1'h1
`define XPS_SEL_ALL_OUTPUTS_TO_INPUT_ZERO 3'h0
`define XPS_OFF_ALL_OUTPUTS_TO_INPUT_ZERO 1'h0
`define XPS_WORD_RST 16'h0000

`endif

// ==== rtl/xps_pkg.sv ====
// types of the crosspoint serial configuration block
`default_nettype none
`include "xps_defines.svh"
package xps_pkg;
  typedef enum logic {
    XPS_MODE_SERIAL = 1'b0,
    XPS_MODE_ADDR = 1'b1
  } xps_mode_type;
  typedef logic [`XPS_FRAME_W-1:0] xps_word_type;
endpackage
`default_nettype wire

// ==== rtl/xps_link_if.sv ====
// carrier between link-clock shifter and core
`default_nettype none
`include "xps_defines.svh"
interface xps_link_if;
  logic [`XPS_FRAME_W-1:0] word;
  logic [`XPS_CNT_W-1:0] new_tgl;
  logic dout;
  modport link (output word, output new_tgl, output dout);
  modport core (input word, input new_tgl, input dout);
endinterface
`default_nettype wire

// ==== rtl/xps_sync.sv ====
// three-stage synchroniser, change taken once stages two and three agree
`default_nettype none
module xps_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;

  always_ff @(posedge clk)
  begin
    s1_q <= async_in;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge clk)
    begin
      if (s2_q[i] == s3_q[i])
      begin
        out_q[i] <= s3_q[i];
      end
    end
  end

  assign sync_out = out_q;
endmodule
`default_nettype wire

// ==== rtl/xps_link.sv ====
// serial-clock side: arming, load shift register, serial out
`default_nettype none
`include "xps_defines.svh"
module xps_link
  import xps_pkg::*;
(
  input wire logic sclk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic din,
  xps_link_if.link lnk
);
  logic link_rst;
  logic armed_q;
  logic [`XPS_CNT_W-1:0] tgl_q;
  logic [`XPS_CNT_W-1:0] cnt_q;
  logic [`XPS_CNT_W-1:0] cnt_nx;
  logic dout_q;
  xps_word_type sr_q;
  logic shift_en;

  // ****************************************************************
  // reset brought onto the serial clock
  // ****************************************************************
  xps_sync #(.W(1)) u_rst_sync (
    .clk(sclk),
    .async_in(srst),
    .sync_out(link_rst)
  );

  // ****************************************************************
  // arming on rising edge while selected
  // ****************************************************************
  always_ff @(posedge sclk)
  begin
    if (link_rst)
    begin
      armed_q <= 1'b0;
    end
    else
    begin
      armed_q <= !cs_n;
    end
  end

  assign shift_en = armed_q && !cs_n;
  // gray count of shifted bits, so even bit counts still read as new
  assign cnt_nx = cnt_q + `XPS_CNT_ONE;

  // ****************************************************************
  // load shift register, falling edge
  // ****************************************************************
  always_ff @(negedge sclk)
  begin
    if (link_rst)
    begin
      sr_q <= `XPS_WORD_RST;
      cnt_q <= `XPS_CNT_RST;
      tgl_q <= `XPS_CNT_RST;
      dout_q <= 1'b0;
    end
    else if (shift_en)
    begin
      sr_q <= {din, sr_q[`XPS_FRAME_W-1:1]};
      dout_q <= sr_q[0];
      cnt_q <= cnt_nx;
      tgl_q <= cnt_nx ^ (cnt_nx >> 1);
    end
  end

  assign lnk.word = sr_q;
  assign lnk.new_tgl = tgl_q;
  assign lnk.dout = dout_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_ignore_deselected;
    @(negedge sclk) disable iff (link_rst) cs_n |=> $stable(sr_q);
  endproperty
  a_ignore_deselected: assert property (p_ignore_deselected) else $error("shift while deselected");

  property p_first_bit_in;
    @(negedge sclk) disable iff (link_rst) shift_en |=> sr_q[`XPS_FRAME_W-1] == $past(din);
  endproperty
  a_first_bit_in: assert property (p_first_bit_in) else $error("data bit not taken");

  property p_shift_out;
    @(negedge sclk) disable iff (link_rst)
      shift_en |=> dout_q == $past(sr_q[0]) && $countones(tgl_q ^ $past(tgl_q)) == 1;
  endproperty
  a_shift_out: assert property (p_shift_out) else $error("serial out wrong");

  property p_arm_clear;
    @(posedge sclk) disable iff (link_rst) cs_n |=> !armed_q;
  endproperty
  a_arm_clear: assert property (p_arm_clear) else $error("armed while deselected");
endmodule
`default_nettype wire

// ==== tb/xps_ctl_model.sv ====
// controller model: serial clock, select and data toward the device
`default_nettype none
module xps_ctl_model (
  output logic sclk,
  output logic cs_n,
  output logic din
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // ********
  // frame of n bits, bit 0 first, clock stops low after last
  // ********
  task automatic send(input logic [31:0] bits, input int n);
    cs_n = 1'b0;
    #4;
    sclk = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      din = bits[i];
      #3;
      sclk = 1'b0;
      #3;
      if (i < n - 1)
        sclk = 1'b1;
    end
    cs_n = 1'b1;
    din = ~din;
  endtask
  // clock pulses while deselected, data toggling
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++)
    begin
      din = ~din;
      #3;
      sclk = 1'b1;
      #3;
      sclk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_xps_crosspoint_cfg.sv ====
// bench for the crosspoint serial configuration block
`default_nettype none
`include "xps_defines.svh"
module tb_xps_crosspoint_cfg;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic srst, cfg, mode, reset_all_off, all_outputs_to_input_zero, look;
  logic sclk, cs_n, din, serial_out;
  logic [`XPS_NOUT*`XPS_SEL_W-1:0] out_sel;
  logic [`XPS_NOUT-1:0] out_off;
  logic [15:0] rnd, cur, old;
  logic [19:0] big;
  logic [5:0] w;
  logic [15:0] oq[$];
  logic so_q[$];
  int failures = 0;
  int comparisons = 0;

  always #5 clk = ~clk;

  xps_ctl_model xps_ctl_model_i (.sclk(sclk), .cs_n(cs_n), .din(din));
  xps_crosspoint_cfg xps_crosspoint_cfg_i (
    .clk(clk),
    .srst(srst),
    .sclk(sclk),
    .cs_n(cs_n),
    .din(din),
    .cfg(cfg),
    .mode(mode),
    .reset_all_off(reset_all_off),
    .all_outputs_to_input_zero(all_outputs_to_input_zero),
    .serial_out(serial_out),
    .out_sel(out_sel),
    .out_off(out_off)
  );

  // ********
  // helpers
  // ********
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic logic [15:0] frame_exp(input logic [15:0] f);
    logic [15:0] e;
    for (int n = 0; n < 4; n++)
    begin
      e[4 + 3 * n +: 3] = f[4 * n +: 3];
      e[n] = f[4 * n + 3];
    end
    return e;
  endfunction

  task automatic compare(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic expect_out(input logic [15:0] v);
    oq.push_back(v);
    repeat (8) @(negedge clk);
    look = 1'b1;
    @(negedge clk);
    look = 1'b0;
  endtask

  task automatic apply();
    repeat (6) @(negedge clk);
    cfg = 1'b1;
    repeat (6) @(negedge clk);
    cfg = 1'b0;
  endtask

  // ********
  // watchers
  // ********
  always @(posedge clk)
    if (look === 1'b1)
      compare({out_sel, out_off}, oq.pop_front());

  always @(negedge sclk)
    if (cs_n === 1'b0 && so_q.size() > 0)
    begin
      #1;
      compare({15'h0000, serial_out}, {15'h0000, so_q.pop_front()});
    end

  initial
  begin
    #300us;
    failures++;
    complete_run();
  end

  // ********
  // sequence
  // ********
  initial
  begin
    srst = 1'b1;
    cfg = 1'b0;
    mode = 1'b0;
    look = 1'b0;
    reset_all_off = 1'b0;
    all_outputs_to_input_zero = 1'b0;
    rnd = 16'h0053;
    xps_ctl_model_i.pulses(4);
    repeat (20) @(negedge clk);
    srst = 1'b0;
    xps_ctl_model_i.pulses(4);
    cur = 16'h000f;
    expect_out(cur);
    for (int k = 0; k < 3; k++)
    begin
      rnd = lfsr_next(rnd);
      xps_ctl_model_i.send({16'h0000, rnd}, 16);
      cur = frame_exp(rnd);
      apply();
      expect_out(cur);
    end
    old = rnd;
    rnd = lfsr_next(rnd);
    big = {rnd, rnd[7:4]};
    for (int i = 0; i < 20; i++)
      so_q.push_back(i < 16 ? old[i] : big[i - 16]);
    xps_ctl_model_i.send({12'h000, big}, 20);
    compare(16'(so_q.size()), 16'h0000);
    apply();
    cur = frame_exp(big[19:4]);
    expect_out(cur);
    all_outputs_to_input_zero = 1'b1;
    cur = 16'h0000;
    expect_out(cur);
    all_outputs_to_input_zero = 1'b0;
    apply();
    expect_out(cur);
    reset_all_off = 1'b1;
    rnd = lfsr_next(rnd);
    xps_ctl_model_i.send({16'h0000, rnd}, 16);
    expect_out(16'h000f);
    all_outputs_to_input_zero = 1'b1;
    expect_out(16'h000f);
    reset_all_off = 1'b0;
    all_outputs_to_input_zero = 1'b0;
    expect_out(16'h000f);
    apply();
    cur = frame_exp(rnd);
    expect_out(cur);
    xps_ctl_model_i.pulses(8);
    apply();
    expect_out(cur);
    mode = 1'b1;
    for (int o = 0; o < 4; o++)
    begin
      rnd = lfsr_next(rnd);
      w = {rnd[3:0], 2'(o)};
      xps_ctl_model_i.send({26'h0, w}, 6);
      xps_ctl_model_i.pulses(1);
      apply();
      cur[4 + 3 * o +: 3] = w[4:2];
      cur[o] = w[5];
      expect_out(cur);
    end
    complete_run();
  end
endmodule
`default_nettype wire
